/* File: hw/image_map_pkg.sv */
// constants for the process image address map
package image_map_pkg;
  localparam int unsigned IMG_BYTES = 128;
  localparam logic [6:0] DIG_LAST = 7'h1F;
  localparam logic [6:0] ONB_IN_LO = 7'h20;
  localparam logic [6:0] ONB_IN_HI = 7'h21;
  localparam logic [6:0] ONB_OUT_FS = 7'h20;
  localparam logic [6:0] ONB_OUT_NFS_HI = 7'h22;
  localparam logic [6:0] DIAG_BYTE = 7'h23;
  localparam logic [6:0] CNT_LO = 7'h24;
  localparam logic [6:0] CNT_HI = 7'h27;
  localparam logic [6:0] IFB_LO = 7'h28;
  localparam logic [6:0] IFB_HI = 7'h37;
  localparam logic [6:0] IRQ_LO = 7'h38;
  localparam logic [6:0] IRQ_HI = 7'h3F;
  localparam logic [6:0] ANA_BASE = 7'h40;
  localparam logic [4:0] ANA_LAST_SLOT = 5'h07;
  localparam logic [15:0] IN_IMG_BASE = 16'h6300;
  localparam logic [15:0] OUT_IMG_BASE = 16'h6380;
  localparam int unsigned ANA_SLOT_SHIFT = 3;
  localparam int unsigned ANA_CH_SHIFT = 1;
  typedef enum logic [1:0] {
    MOD_NONE = 2'h0,
    MOD_DIGITAL = 2'h1,
    MOD_ANALOG = 2'h2,
    MOD_DIO16 = 2'h3
  } module_kind_e;
  typedef enum logic [1:0] {
    W_BIT = 2'h0,
    W_BYTE = 2'h1,
    W_WORD = 2'h2
  } access_width_e;
  typedef enum logic [2:0] {
    AREA_DIGITAL = 3'h0,
    AREA_ONBOARD = 3'h1,
    AREA_IFB = 3'h2,
    AREA_IRQ = 3'h3,
    AREA_ANALOG = 3'h4
  } area_e;
endpackage

/* File: hw/process_image_address_map.sv */
// slot/channel to process image address translation and image storage
`timescale 1ns/1ps
`default_nettype none
module process_image_address_map
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // slot configuration, written by the bus scan
  input wire logic cfg_we_i,
  input wire logic [4:0] cfg_slot_i,
  input wire image_map_pkg::module_kind_e cfg_kind_i,
  input wire logic cfg_failsafe_i,
  // address request from the program
  input wire logic [4:0] req_slot_i,
  input wire logic [1:0] req_chan_i,
  input wire logic [2:0] req_bit_i,
  input wire logic req_hi_i,
  output logic [6:0] map_byte_o,
  output logic [2:0] map_bit_o,
  output logic [15:0] map_in_addr_o,
  output logic [15:0] map_out_addr_o,
  output logic map_ok_o,
  // program access to the images
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic acc_out_img_i,
  input wire image_map_pkg::access_width_e acc_width_i,
  input wire logic [6:0] acc_byte_i,
  input wire logic [2:0] acc_bit_i,
  input wire logic [15:0] acc_wdata_i,
  output logic [15:0] acc_rdata_o,
  output logic acc_err_o,
  // data cycle: module side
  input wire logic cyc_in_we_i,
  input wire logic [6:0] cyc_byte_i,
  input wire logic [7:0] cyc_in_data_i,
  input wire logic cyc_end_i,
  output logic [7:0] cyc_out_data_o,
  output logic [7:0] diag_cfg_o
);
  import image_map_pkg::*;

  module_kind_e kind [IMG_BYTES/4];
  logic fs [IMG_BYTES/4];
  logic [7:0] in_stage [IMG_BYTES];
  logic [7:0] in_img [IMG_BYTES];
  logic [7:0] out_img [IMG_BYTES];
  logic [15:0] next_rdata;
  logic next_err;

  function automatic logic [6:0] ana_start(input logic [2:0] s,
                                          input logic [1:0] c);
    ana_start = ANA_BASE + 7'({s, 3'h0}) + 7'({c, 1'b0});
  endfunction

  function automatic logic slot_ok(input module_kind_e k,
                                   input logic [4:0] s);
    case (k)
      MOD_ANALOG: slot_ok = (s <= ANA_LAST_SLOT);
      MOD_DIO16: slot_ok = (s <= ANA_LAST_SLOT);
      MOD_DIGITAL: slot_ok = (s <= DIG_LAST[4:0]);
      default: slot_ok = 1'b1;
    endcase
  endfunction

  // byte belongs to an analog area slot, or to a digital slot
  function automatic logic [4:0] owner_slot(input logic [6:0] b);
    if (b >= ANA_BASE)
      owner_slot = {2'h0, b[5:3]};
    else
      owner_slot = b[4:0];
  endfunction

  function automatic logic byte_empty(input logic [6:0] b,
                                      input module_kind_e k);
    if (b >= ANA_BASE)
      byte_empty = !(k == MOD_ANALOG || (k == MOD_DIO16 && b[2:1] == 2'h0));
    else if (b <= DIG_LAST)
      byte_empty = (k != MOD_DIGITAL);
    else
      byte_empty = 1'b0;
  endfunction

  function automatic area_e area_of(input logic [6:0] b);
    if (b <= DIG_LAST)
      area_of = AREA_DIGITAL;
    else if (b <= CNT_HI)
      area_of = AREA_ONBOARD;
    else if (b <= IFB_HI)
      area_of = AREA_IFB;
    else if (b <= IRQ_HI)
      area_of = AREA_IRQ;
    else
      area_of = AREA_ANALOG;
  endfunction

  // slot numbers already interleave subunits and tiers upstream
  always_comb
  begin
    map_bit_o = req_bit_i;
    map_ok_o = slot_ok(kind[req_slot_i], req_slot_i);
    case (kind[req_slot_i])
      MOD_ANALOG: map_byte_o = ana_start(req_slot_i[2:0], req_chan_i);
      MOD_DIO16: map_byte_o = ana_start(req_slot_i[2:0], 2'h0)
                              + 7'(req_hi_i);
      default: map_byte_o = {2'h0, req_slot_i};
    endcase
    map_in_addr_o = IN_IMG_BASE + 16'(map_byte_o);
    map_out_addr_o = OUT_IMG_BASE + 16'(map_byte_o);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < IMG_BYTES/4; i++)
      begin
        kind[i] <= MOD_NONE;
        fs[i] <= 1'b0;
      end
    end
    else if (cfg_we_i && slot_ok(cfg_kind_i, cfg_slot_i))
    begin
      kind[cfg_slot_i] <= cfg_kind_i;
      fs[cfg_slot_i] <= cfg_failsafe_i;
    end
  end

  // staging holds data-cycle input until the program cycle starts
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < IMG_BYTES; i++)
      begin
        in_stage[i] <= 8'h00;
        in_img[i] <= 8'h00;
      end
    end
    else
    begin
      if (cyc_in_we_i)
        in_stage[cyc_byte_i] <= cyc_in_data_i;
      if (cyc_end_i)
        for (int i = 0; i < IMG_BYTES; i++)
          in_img[i] <= in_stage[i];
    end
  end

  logic wr_ok;
  assign wr_ok = acc_valid_i && acc_write_i && acc_out_img_i && !next_err;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < IMG_BYTES; i++)
        out_img[i] <= 8'h00;
    end
    else if (wr_ok)
    begin
      case (acc_width_i)
        W_BIT: out_img[acc_byte_i][acc_bit_i] <= acc_wdata_i[0];
        W_BYTE: out_img[acc_byte_i] <= acc_wdata_i[7:0];
        default:
        begin
          out_img[acc_byte_i] <= acc_wdata_i[15:8];
          out_img[7'(acc_byte_i + 7'h01)] <= acc_wdata_i[7:0];
        end
      endcase
    end
  end

  logic [4:0] acc_slot;
  logic [6:0] acc_next;
  logic ext_area;
  area_e acc_area;
  assign acc_slot = owner_slot(acc_byte_i);
  assign acc_next = 7'(acc_byte_i + 7'h01);
  assign acc_area = area_of(acc_byte_i);
  assign ext_area = (acc_area == AREA_DIGITAL) || (acc_area == AREA_ANALOG);

  always_comb
  begin
    logic [7:0] hi;
    logic [7:0] lo;
    hi = acc_out_img_i ? out_img[acc_byte_i] : in_img[acc_byte_i];
    lo = acc_out_img_i ? out_img[acc_next] : in_img[acc_next];
    if (ext_area && byte_empty(acc_byte_i, kind[acc_slot]))
      hi = 8'h00;
    if (acc_next == 7'h00 ||
        (ext_area && byte_empty(acc_next, kind[owner_slot(acc_next)])))
      lo = 8'h00;
    next_err = 1'b0;
    if (ext_area && fs[acc_slot])
      next_err = acc_byte_i[0] || (acc_width_i == W_WORD);
    if (acc_byte_i >= ANA_BASE && kind[acc_slot] == MOD_ANALOG &&
        acc_width_i == W_BIT)
      next_err = 1'b1;
    if (acc_width_i == W_WORD && acc_byte_i == 7'h7F)
      next_err = 1'b1;
    case (acc_width_i)
      W_BIT: next_rdata = {15'h0000, hi[acc_bit_i]};
      W_BYTE: next_rdata = {8'h00, hi};
      default: next_rdata = {hi, lo};
    endcase
    if (!acc_valid_i || acc_write_i || next_err)
      next_rdata = 16'h0000;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      acc_rdata_o <= 16'h0000;
      acc_err_o <= 1'b0;
    end
    else
    begin
      acc_rdata_o <= next_rdata;
      acc_err_o <= acc_valid_i && next_err;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cyc_out_data_o <= 8'h00;
      diag_cfg_o <= 8'h00;
    end
    else
    begin
      cyc_out_data_o <= out_img[cyc_byte_i];
      diag_cfg_o <= out_img[DIAG_BYTE];
    end
  end

  // fixed areas 32..63 pass straight through to the images
  dio16_addr_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    kind[req_slot_i] == MOD_DIO16 && req_slot_i <= ANA_LAST_SLOT
    |-> map_byte_o - ANA_BASE == 7'({req_slot_i[2:0], 3'h0})
        + 7'(req_hi_i))
    else $error("combined module byte wrong");
  ana_addr_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    kind[req_slot_i] == MOD_ANALOG
    |-> map_byte_o >= ANA_BASE && map_byte_o[0] == 1'b0)
    else $error("analog byte out of area");
  dig_addr_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    kind[req_slot_i] == MOD_DIGITAL
    |-> map_byte_o == {2'h0, req_slot_i})
    else $error("digital byte not slot");
  same_addr_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    map_out_addr_o - map_in_addr_o == OUT_IMG_BASE - IN_IMG_BASE)
    else $error("in and out addresses differ");
  fs_word_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    acc_valid_i && ext_area && fs[acc_slot] && acc_width_i == W_WORD
    |=> acc_err_o && acc_rdata_o == 16'h0000)
    else $error("failsafe word access not rejected");
  empty_zero_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    acc_valid_i && !acc_write_i && acc_width_i == W_BYTE &&
    acc_byte_i <= DIG_LAST && kind[acc_slot] == MOD_NONE
    |=> acc_rdata_o == 16'h0000)
    else $error("empty slot read not zero");
  visible_next_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    cyc_in_we_i && !cyc_end_i ##1 !cyc_in_we_i && cyc_end_i
    |=> in_img[$past(cyc_byte_i, 2)] == $past(cyc_in_data_i, 2))
    else $error("captured input not visible");
  ana_slot_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    cfg_we_i && cfg_kind_i == MOD_ANALOG && cfg_slot_i > ANA_LAST_SLOT
    |=> kind[$past(cfg_slot_i)] != MOD_ANALOG)
    else $error("analog accepted in high slot");
  fs_odd_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    acc_valid_i && ext_area && fs[acc_slot] && acc_byte_i[0]
    |=> acc_err_o)
    else $error("failsafe odd byte not rejected");
  ana_bit_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    acc_valid_i && acc_byte_i >= ANA_BASE &&
    kind[acc_slot] == MOD_ANALOG && acc_width_i == W_BIT
    |=> acc_err_o)
    else $error("analog bit access not rejected");
  fixed_area_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    acc_valid_i && acc_area != AREA_DIGITAL &&
    acc_area != AREA_ANALOG && acc_width_i != W_WORD
    |=> !acc_err_o)
    else $error("fixed area access rejected");
  out_byte_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    wr_ok && acc_width_i == W_BYTE
    |=> out_img[$past(acc_byte_i)] == $past(acc_wdata_i[7:0]))
    else $error("output byte not written");
  err_nowrite_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    acc_valid_i && acc_write_i && next_err
    |=> out_img[$past(acc_byte_i)] == $past(out_img[acc_byte_i]))
    else $error("rejected write changed image");
  in_hold_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !cyc_end_i
    |=> in_img[$past(acc_byte_i)] == $past(in_img[acc_byte_i]))
    else $error("input image changed mid cycle");
  diag_follow_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    1'b1 |=> diag_cfg_o == $past(out_img[DIAG_BYTE]))
    else $error("config byte not shown");
  idle_quiet_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !acc_valid_i |=> acc_rdata_o == 16'h0000 && !acc_err_o)
    else $error("idle access not quiet");
  dio16_slot_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    cfg_we_i && cfg_kind_i == MOD_DIO16 && cfg_slot_i > ANA_LAST_SLOT
    |=> kind[$past(cfg_slot_i)] != MOD_DIO16)
    else $error("combined module accepted in high slot");
endmodule
`default_nettype wire

/* File: tb/plug_in_io_model.sv */
// plug-in module model on the data cycle side
`timescale 1ns/1ps
`default_nettype none
module plug_in_io_model
(
  // clock
  input wire logic clk_i,
  // data cycle
  output logic we_o,
  output logic [6:0] byte_o,
  output logic [7:0] data_o,
  output logic end_o,
  input wire logic [7:0] out_i
);
  initial
  begin
    we_o = 1'b0;
    byte_o = 7'h00;
    data_o = 8'h00;
    end_o = 1'b0;
  end
  task automatic stage(input logic [6:0] b, input logic [7:0] d);
    @(posedge clk_i);
    we_o <= 1'b1;
    byte_o <= b;
    data_o <= d;
    @(posedge clk_i);
    we_o <= 1'b0;
    data_o <= ~d; // released line shows no stale value
  endtask
  task automatic end_cycle();
    end_o <= 1'b1;
    @(posedge clk_i);
    end_o <= 1'b0;
  endtask
  task automatic fetch(input logic [6:0] b, output logic [7:0] d);
    @(posedge clk_i);
    byte_o <= b;
    @(posedge clk_i);
    #1 d = out_i;
  endtask
endmodule
`default_nettype wire

/* File: tb/process_image_address_map_tb.sv */
// self-checking bench for the process image address map
`timescale 1ns/1ps
`default_nettype none
module process_image_address_map_tb;
  import image_map_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cwe = 1'b0;
  logic [4:0] cslot = 5'h00;
  module_kind_e ckind = MOD_NONE;
  logic cfs = 1'b0;
  logic [4:0] rslot = 5'h00;
  logic [1:0] rch = 2'h0;
  logic [2:0] rbit = 3'h0;
  logic rhi = 1'b0;
  logic [6:0] mbyte;
  logic [2:0] mbit;
  logic [15:0] min, mout;
  logic mok, err, cwe2, cend;
  logic av = 1'b0;
  logic aw = 1'b0;
  logic ao = 1'b0;
  access_width_e awid = W_BYTE;
  logic [6:0] ab = 7'h00;
  logic [6:0] cb;
  logic [2:0] abit = 3'h0;
  logic [15:0] ad = 16'h0000;
  logic [15:0] rd;
  logic [7:0] cin, cout, diag, got;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  process_image_address_map u_process_image_address_map (.clk_i(clk),
    .rstn_i(rstn), .cfg_we_i(cwe), .cfg_slot_i(cslot), .cfg_kind_i(ckind),
    .cfg_failsafe_i(cfs), .req_slot_i(rslot), .req_chan_i(rch),
    .req_bit_i(rbit), .req_hi_i(rhi), .map_byte_o(mbyte), .map_bit_o(mbit),
    .map_in_addr_o(min), .map_out_addr_o(mout), .map_ok_o(mok),
    .acc_valid_i(av), .acc_write_i(aw), .acc_out_img_i(ao),
    .acc_width_i(awid), .acc_byte_i(ab), .acc_bit_i(abit),
    .acc_wdata_i(ad), .acc_rdata_o(rd), .acc_err_o(err),
    .cyc_in_we_i(cwe2), .cyc_byte_i(cb), .cyc_in_data_i(cin),
    .cyc_end_i(cend), .cyc_out_data_o(cout), .diag_cfg_o(diag));
  plug_in_io_model u_plug_in_io_model (.clk_i(clk), .we_o(cwe2),
    .byte_o(cb), .data_o(cin), .end_o(cend), .out_i(cout));
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    comparisons++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask
  task automatic cfg(logic [4:0] s, module_kind_e k, logic f);
    @(posedge clk);
    cwe <= 1'b1;
    cslot <= s;
    ckind <= k;
    cfs <= f;
    @(posedge clk);
    cwe <= 1'b0;
  endtask
  task automatic map(logic [4:0] s, logic [1:0] c, logic [2:0] b, logic h,
    logic [6:0] eb);
    @(posedge clk);
    rslot <= s;
    rch <= c;
    rbit <= b;
    rhi <= h;
    #1 chk("map_byte", {9'h000, eb}, {9'h000, mbyte});
    chk("map_bit", {13'h0000, b}, {13'h0000, mbit});
    chk("map_in", IN_IMG_BASE + {9'h000, eb}, min);
    chk("map_out", OUT_IMG_BASE + {9'h000, eb}, mout);
    chk("map_ok", 16'h0001, {15'h0000, mok});
  endtask
  task automatic acc(logic w, logic o, access_width_e wd, logic [6:0] b,
    logic [15:0] d, logic [15:0] er, logic ee);
    @(posedge clk);
    av <= 1'b1;
    aw <= w;
    ao <= o;
    awid <= wd;
    ab <= b;
    abit <= 3'h1;
    ad <= d;
    @(posedge clk);
    av <= 1'b0;
    #1 chk("acc_rdata", er, rd);
    chk("acc_err", {15'h0000, ee}, {15'h0000, err});
  endtask
  task automatic test_slots();
    cfg(5'h03, MOD_DIGITAL, 1'b0);
    map(5'h03, 2'h0, 3'h1, 1'b0, 7'h03);
    cfg(5'h05, MOD_ANALOG, 1'b0);
    map(5'h05, 2'h1, 3'h0, 1'b0, 7'h6A);
    cfg(5'h07, MOD_ANALOG, 1'b0);
    map(5'h07, 2'h3, 3'h0, 1'b0, 7'h7E);
    cfg(5'h04, MOD_DIO16, 1'b0);
    map(5'h04, 2'h0, 3'h4, 1'b0, 7'h60);
    cfg(5'h06, MOD_DIO16, 1'b0);
    map(5'h06, 2'h0, 3'h3, 1'b1, 7'h71);
  endtask
  task automatic test_inputs();
    u_plug_in_io_model.stage(7'h03, 8'h5A);
    acc(1'b0, 1'b0, W_BYTE, 7'h03, 16'h0000, 16'h0000, 1'b0);
    u_plug_in_io_model.stage(7'h09, 8'hFF);
    u_plug_in_io_model.stage(7'h6A, 8'h12);
    u_plug_in_io_model.stage(7'h6B, 8'h34);
    u_plug_in_io_model.end_cycle();
    acc(1'b0, 1'b0, W_BYTE, 7'h03, 16'h0000, 16'h005A, 1'b0);
    acc(1'b0, 1'b0, W_BIT, 7'h03, 16'h0000, 16'h0001, 1'b0);
    acc(1'b0, 1'b0, W_BYTE, 7'h09, 16'h0000, 16'h0000, 1'b0);
    acc(1'b0, 1'b0, W_WORD, 7'h6A, 16'h0000, 16'h1234, 1'b0);
  endtask
  task automatic test_outputs();
    acc(1'b1, 1'b1, W_BYTE, 7'h23, 16'h00A5, 16'h0000, 1'b0);
    @(posedge clk);
    #1 chk("diag_cfg", 16'h00A5, {8'h00, diag});
    acc(1'b1, 1'b1, W_BYTE, 7'h60, 16'h003C, 16'h0000, 1'b0);
    u_plug_in_io_model.fetch(7'h60, got);
    chk("cyc_out", 16'h003C, {8'h00, got});
  endtask
  task automatic test_errors();
    cfg(5'h02, MOD_DIGITAL, 1'b1);
    acc(1'b0, 1'b0, W_WORD, 7'h02, 16'h0000, 16'h0000, 1'b1);
    acc(1'b0, 1'b0, W_BYTE, 7'h02, 16'h0000, 16'h0000, 1'b0);
    acc(1'b0, 1'b0, W_BIT, 7'h6A, 16'h0000, 16'h0000, 1'b1);
    acc(1'b0, 1'b0, W_WORD, 7'h7F, 16'h0000, 16'h0000, 1'b1);
  endtask
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    test_slots();
    test_inputs();
    test_outputs();
    test_errors();
    conclude();
  end
endmodule
`default_nettype wire
